// ==== ring_osc_counters.sv ====
module ring_osc_counters #(
	parameter int NUM = 4,
	parameter int WIDTH = 16
) (
	input wire logic clk,
	input wire logic [NUM-1:0] run,
	input wire logic [NUM-1:0] osc_edge,
	output logic [NUM*WIDTH-1:0] count
);
	genvar i;
	generate
		for (i = 0; i < NUM; i++) begin : g_osc
			// Power-up value only; no reset, so counts survive system reset
			logic [WIDTH-1:0] cnt = '0;
			logic [WIDTH-1:0] next_cnt;
			// Edges come from free-running oscillators, not the tile clock
			always_comb begin
				next_cnt = cnt;
				if (run[i] && osc_edge[i]) begin
					next_cnt = cnt + 1'b1;
				end
			end
			always_ff @(posedge clk) begin
				cnt <= next_cnt;
			end
			assign count[i*WIDTH +: WIDTH] = cnt;
		end
	endgenerate
endmodule

// ==== test_tile_status_control_regs.sv ====
`include "tile_status_regs.svh"

module test_tile_status_control_regs
	import tile_status_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int LP = 4;
	logic clk, rst, ps_req, ps_we, ps_ack, ps_refused, otp_load;
	logic [15:0] ps_res;
	logic [31:0] ps_wdata, ps_rdata, otp_word;
	logic [7:0] processor_number;
	logic [1:0] boot_pll_pins;
	logic boot_from_ram, boot_from_jtag, second_core_off, skip_otp_poll, all_threads_paused;
	logic [3:0] osc_edge, otp_sector_lock;
	logic rgmii_tx_clk, rgmii_tx_strobe, rgmii_ports_en, lp_clk_en, usb_utmi_sel;
	logic ulpi_support_en, boot_from_otp, jtag_cfg_block, global_debug_off, jtag_tap_off;
	logic otp_lock_all, otp_redundancy;
	logic [63:0] osc_count;
	int miscompares = 0;
	int checks_done = 0;

	tile_status_control_regs #(.LP_DIV(LP), .OSC_WIDTH(16)) dut (
		.clk(clk), .rst(rst), .ps_req(ps_req), .ps_we(ps_we), .ps_res(ps_res),
		.ps_wdata(ps_wdata), .ps_ack(ps_ack), .ps_refused(ps_refused), .ps_rdata(ps_rdata),
		.otp_load(otp_load), .otp_word(otp_word), .processor_number(processor_number),
		.boot_pll_pins(boot_pll_pins), .boot_from_ram(boot_from_ram),
		.boot_from_jtag(boot_from_jtag), .second_core_off(second_core_off),
		.skip_otp_poll(skip_otp_poll), .all_threads_paused(all_threads_paused),
		.osc_edge(osc_edge), .rgmii_tx_clk(rgmii_tx_clk), .rgmii_tx_strobe(rgmii_tx_strobe),
		.rgmii_ports_en(rgmii_ports_en), .lp_clk_en(lp_clk_en), .usb_utmi_sel(usb_utmi_sel),
		.ulpi_support_en(ulpi_support_en), .boot_from_otp(boot_from_otp),
		.jtag_cfg_block(jtag_cfg_block), .global_debug_off(global_debug_off),
		.jtag_tap_off(jtag_tap_off), .otp_lock_all(otp_lock_all),
		.otp_sector_lock(otp_sector_lock), .otp_redundancy(otp_redundancy),
		.osc_count(osc_count)
	);

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic results();
		$display("checks %0d miscompares %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask

	task automatic access(input logic we, input logic [15:0] res, input logic [31:0] wd,
			output logic [31:0] rd, output logic ack, output logic refd);
		@(posedge clk);
		ps_req <= 1'b1;
		ps_we <= we;
		ps_res <= res;
		ps_wdata <= wd;
		@(posedge clk);
		ps_req <= 1'b0;
		#1;
		rd = ps_rdata;
		ack = ps_ack;
		refd = ps_refused;
	endtask

	task automatic wr(input logic [7:0] num, input logic [31:0] d, input logic exp_ref);
		logic [31:0] r;
		logic a, f;
		access(1'b1, {num, `PS_RES_TYPE}, d, r, a, f);
		check({30'h0, a, f}, {30'h0, 1'b1, exp_ref}, "write ack");
	endtask

	task automatic rd(input logic [7:0] num, input logic [31:0] exp);
		logic [31:0] r;
		logic a, f;
		access(1'b0, {num, `PS_RES_TYPE}, 32'h0, r, a, f);
		check({31'h0, a}, 32'h1, "read ack");
		check(r, exp, "read data");
	endtask

	task automatic reset_regs();
		@(posedge clk);
		rst <= 1'b1;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
	endtask

	task automatic t_reset_values();
		rd(`REG_TILE_CONTROL, 32'h0);
		rd(`REG_SECURITY_CONFIG, 32'h0);
		rd(`REG_RING_OSC_CONTROL, 32'h0);
		check({31'h0, lp_clk_en}, 32'h1, "lp enable idle");
	endtask

	task automatic t_control();
		wr(`REG_TILE_CONTROL, 32'hffff_ffff, 1'b0);
		rd(`REG_TILE_CONTROL, 32'h03ff_ff36);
		check({29'h0, rgmii_ports_en, usb_utmi_sel, ulpi_support_en}, 32'h7, "ctl pins");
		wr(`REG_TILE_CONTROL, 32'h0000_0004, 1'b0);
		check({29'h0, rgmii_ports_en, usb_utmi_sel, ulpi_support_en}, 32'h2, "ctl pins");
		wr(`REG_TILE_CONTROL, 32'h0000_0002, 1'b0);
		check({29'h0, rgmii_ports_en, usb_utmi_sel, ulpi_support_en}, 32'h1, "ctl pins");
	endtask

	task automatic otp(input logic [31:0] w);
		@(posedge clk);
		otp_load <= 1'b1;
		otp_word <= w;
		@(posedge clk);
		otp_load <= 1'b0;
		@(posedge clk);
	endtask

	task automatic t_security();
		otp(32'h7fff_ffff);
		rd(`REG_SECURITY_CONFIG, 32'h0000_5fb1);
		check({22'h0, boot_from_otp, jtag_cfg_block, global_debug_off, jtag_tap_off,
			otp_lock_all, otp_sector_lock, otp_redundancy}, 32'h3ff, "security pins");
		wr(`REG_SECURITY_CONFIG, 32'h8000_0000, 1'b0);
		check({22'h0, boot_from_otp, jtag_cfg_block, global_debug_off, jtag_tap_off,
			otp_lock_all, otp_sector_lock, otp_redundancy}, 32'h0, "security pins");
		wr(`REG_SECURITY_CONFIG, 32'h0000_1f21, 1'b1);
		rd(`REG_SECURITY_CONFIG, 32'h8000_0000);
		reset_regs();
		wr(`REG_SECURITY_CONFIG, 32'h0000_0020, 1'b0);
		rd(`REG_SECURITY_CONFIG, 32'h0000_0020);
		check({31'h0, boot_from_otp}, 32'h1, "otp boot");
	endtask

	task automatic boot_case(input logic [7:0] pn, input logic [1:0] pll, input logic [3:0] f,
			input logic ovr);
		@(posedge clk);
		processor_number <= pn;
		boot_pll_pins <= pll;
		{second_core_off, skip_otp_poll, boot_from_ram, boot_from_jtag} <= f;
		repeat (3) @(posedge clk);
		rd(`REG_TILE_BOOT_STATUS, {8'h0, pn, 7'h0, ovr, 2'h0, f, pll});
		wr(`REG_TILE_BOOT_STATUS, 32'hffff_ffff, 1'b0);
		rd(`REG_TILE_BOOT_STATUS, {8'h0, pn, 7'h0, ovr, 2'h0, f, pll});
	endtask

	task automatic t_tx(input int div, input int dly, input logic en, input int rises,
			input int highs);
		int nr, nh, ns, last;
		logic prev;
		nr = 0;
		nh = 0;
		ns = 0;
		last = -1;
		wr(`REG_TILE_CONTROL, (dly << 18) | (div << 9) | (en << 8), 1'b0);
		repeat (20) @(posedge clk);
		#1;
		prev = rgmii_tx_clk;
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1;
			if (rgmii_tx_clk === 1'b1 && prev === 1'b0) begin
				nr++;
				last = i;
			end
			nh += (rgmii_tx_clk === 1'b1);
			if (rgmii_tx_strobe === 1'b1) begin
				ns++;
				if (last >= 0)
					check(i - last, dly, "strobe delay");
			end
			prev = rgmii_tx_clk;
		end
		check(nr, rises, "tx clock rises");
		check(nh, highs, "tx clock high cycles");
		check(ns, rises, "strobe count");
	endtask

	task automatic t_lp(input logic [31:0] ctl, input logic paused, input int exp);
		int n;
		n = 0;
		@(posedge clk);
		all_threads_paused <= paused;
		wr(`REG_TILE_CONTROL, ctl, 1'b0);
		repeat (8) @(posedge clk);
		for (int i = 0; i < 40; i++) begin
			@(posedge clk);
			#1;
			n += (lp_clk_en === 1'b1);
		end
		check(n, exp, "lp enable count");
	endtask

	task automatic t_misc();
		logic [31:0] r;
		logic a, f;
		logic [63:0] snap;
		rd(8'h04, 32'h0);
		access(1'b0, 16'h0200, 32'h0, r, a, f);
		check({31'h0, a}, 32'h0, "bad resource ack");
		wr(`REG_RING_OSC_CONTROL, 32'hffff_ffff, 1'b0);
		rd(`REG_RING_OSC_CONTROL, 32'h0000_0003);
		wr(`REG_RING_OSC_CONTROL, 32'h0000_0002, 1'b0);
		snap = osc_count;
		repeat (8) @(posedge clk) osc_edge <= ~osc_edge;
		#1;
		check(osc_count[63:32], snap[63:32], "peripheral counters stopped");
		check({31'h0, osc_count[31:0] != snap[31:0]}, 32'h1, "core counters ran");
		rd(`REG_RING_OSC_CONTROL, 32'h0000_0002);
		wr(`REG_RING_OSC_CONTROL, 32'h0000_0000, 1'b0);
		repeat (10) @(posedge clk);
		#1;
		snap = osc_count;
		repeat (8) @(posedge clk) osc_edge <= ~osc_edge;
		#1;
		check(osc_count, snap, "stopped counters held");
	endtask

	initial begin
		#100000;
		miscompares++;
		$display("mismatch at %0t: run did not finish", $time);
		results();
	end

	initial begin
		rst = 1'b1;
		{ps_req, ps_we, otp_load, all_threads_paused} = 4'h0;
		ps_res = 16'h0;
		ps_wdata = 32'h0;
		otp_word = 32'h0;
		processor_number = 8'h0;
		boot_pll_pins = 2'h0;
		{boot_from_ram, boot_from_jtag, second_core_off, skip_otp_poll} = 4'h0;
		osc_edge = 4'h5;
		reset_regs();
		t_reset_values();
		t_control();
		t_security();
		boot_case(8'h5a, 2'h2, 4'ha, 1'b1);
		wr(`REG_SECURITY_CONFIG, 32'h0, 1'b0);
		boot_case(8'ha5, 2'h1, 4'h5, 1'b0);
		t_tx(3, 2, 1'b1, 10, 20);
		t_tx(4, 0, 1'b1, 8, 24);
		t_tx(3, 1, 1'b0, 0, 0);
		t_lp(32'h0000_0000, 1'b0, 40);
		t_lp(32'h0000_0010, 1'b0, 40 / LP);
		t_lp(32'h0000_0030, 1'b0, 40);
		t_lp(32'h0000_0030, 1'b1, 40 / LP);
		t_misc();
		results();
	end
endmodule

// ==== tile_status_control_regs.sv ====
`include "tile_status_regs.svh"

module tile_status_control_regs
	import tile_status_pkg::*;
#(
	parameter int LP_DIV = `LP_DIV_RATIO,
	parameter int OSC_WIDTH = 16
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ps_req,
	input wire logic ps_we,
	input wire logic [15:0] ps_res,
	input wire logic [31:0] ps_wdata,
	output logic ps_ack,
	output logic ps_refused,
	output logic [31:0] ps_rdata,
	input wire logic otp_load,
	input wire logic [31:0] otp_word,
	input wire logic [7:0] processor_number,
	input wire logic [1:0] boot_pll_pins,
	input wire logic boot_from_ram,
	input wire logic boot_from_jtag,
	input wire logic second_core_off,
	input wire logic skip_otp_poll,
	input wire logic all_threads_paused,
	input wire logic [3:0] osc_edge,
	output logic rgmii_tx_clk,
	output logic rgmii_tx_strobe,
	output logic rgmii_ports_en,
	output logic lp_clk_en,
	output logic usb_utmi_sel,
	output logic ulpi_support_en,
	output logic boot_from_otp,
	output logic jtag_cfg_block,
	output logic global_debug_off,
	output logic jtag_tap_off,
	output logic otp_lock_all,
	output logic [3:0] otp_sector_lock,
	output logic otp_redundancy,
	output logic [4*OSC_WIDTH-1:0] osc_count
);
	logic [31:0] tile_control, next_tile_control;
	logic [31:0] tile_boot_status, next_tile_boot_status;
	logic [31:0] security_config, next_security_config;
	logic [31:0] ring_osc_control, next_ring_osc_control;
	logic [31:0] next_ps_rdata;
	logic next_ps_ack, next_ps_refused;
	logic [7:0] reg_num;
	logic hit;

	// Resource id is register number in the upper byte, type in the lower
	assign reg_num = ps_res[15:8];
	assign hit = ps_req && (ps_res[7:0] == `PS_RES_TYPE);

	always_comb begin
		next_tile_control = tile_control;
		next_ring_osc_control = ring_osc_control;
		next_security_config = security_config;
		next_ps_ack = hit;
		next_ps_refused = 1'b0;
		next_ps_rdata = `RST_WORD;
		next_tile_boot_status = `RST_WORD;
		next_tile_boot_status[`BOOT_PROC_HI:`BOOT_PROC_LO] = processor_number;
		next_tile_boot_status[`BOOT_PLL_HI:`BOOT_PLL_LO] = boot_pll_pins;
		next_tile_boot_status[`BOOT_FROM_RAM] = boot_from_ram;
		next_tile_boot_status[`BOOT_FROM_JTAG] = boot_from_jtag;
		next_tile_boot_status[`BOOT_OVERRIDE] = security_config[`SEC_OTP_BOOT];
		next_tile_boot_status[`BOOT_SECOND_CORE_OFF] = second_core_off;
		next_tile_boot_status[`BOOT_SKIP_POLL] = skip_otp_poll;
		if (otp_load) begin
			next_security_config = otp_word & `SEC_WMASK;
		end
		if (hit && ps_we) begin
			case (reg_num)
				`REG_TILE_CONTROL: next_tile_control = ps_wdata & `CTL_WMASK;
				`REG_RING_OSC_CONTROL: next_ring_osc_control = ps_wdata & `OSC_WMASK;
				`REG_SECURITY_CONFIG: begin
					if (security_config[`SEC_WRITE_LOCK]) begin
						next_ps_refused = 1'b1;
					end else if (!otp_load) begin
						next_security_config = ps_wdata & `SEC_WMASK;
					end
				end
				default: next_ps_rdata = `RST_WORD;
			endcase
		end else if (hit) begin
			case (reg_num)
				`REG_TILE_CONTROL: next_ps_rdata = tile_control;
				`REG_TILE_BOOT_STATUS: next_ps_rdata = tile_boot_status;
				`REG_SECURITY_CONFIG: next_ps_rdata = security_config;
				`REG_RING_OSC_CONTROL: next_ps_rdata = ring_osc_control;
				default: next_ps_rdata = `RST_WORD;
			endcase
		end
	end

	// Lock bit clears only by reset or by an OTP load of a word with bit 31 low
	always_ff @(posedge clk) begin
		if (rst) begin
			tile_control <= `RST_WORD;
			tile_boot_status <= `RST_WORD;
			security_config <= `RST_WORD;
			ring_osc_control <= `RST_WORD;
			ps_rdata <= `RST_WORD;
			ps_ack <= 1'b0;
			ps_refused <= 1'b0;
		end else begin
			tile_control <= next_tile_control;
			tile_boot_status <= next_tile_boot_status;
			security_config <= next_security_config;
			ring_osc_control <= next_ring_osc_control;
			ps_rdata <= next_ps_rdata;
			ps_ack <= next_ps_ack;
			ps_refused <= next_ps_refused;
		end
	end

	assign rgmii_ports_en = tile_control[`CTL_RGMII_EN];
	assign usb_utmi_sel = tile_control[`CTL_UTMI_SEL];
	assign ulpi_support_en = tile_control[`CTL_ULPI_EN];
	assign boot_from_otp = security_config[`SEC_OTP_BOOT];
	assign jtag_cfg_block = security_config[`SEC_JTAG_CFG_BLOCK];
	assign global_debug_off = security_config[`SEC_GLOBAL_DEBUG_OFF];
	assign jtag_tap_off = security_config[`SEC_JTAG_TAP_OFF];
	assign otp_lock_all = security_config[`SEC_OTP_LOCK_ALL];
	assign otp_sector_lock = security_config[`SEC_SECTOR_HI:`SEC_SECTOR_LO];
	assign otp_redundancy = security_config[`SEC_OTP_REDUNDANCY];

	// Transmit clock divider and data delay; clk stands for the PLL output
	logic [8:0] tx_div, tx_cnt, next_tx_cnt;
	logic [7:0] tx_dly, dly_cnt, next_dly_cnt;
	logic next_tx_clk, next_tx_strobe;
	delay_state_t dly_state, next_dly_state;

	assign tx_div = tile_control[`CTL_TXDIV_HI:`CTL_TXDIV_LO];
	assign tx_dly = tile_control[`CTL_TXDLY_HI:`CTL_TXDLY_LO];

	always_comb begin
		next_tx_cnt = (tx_cnt >= tx_div) ? 9'h000 : tx_cnt + 9'h001;
		next_tx_clk = rgmii_tx_clk;
		next_dly_state = dly_state;
		next_dly_cnt = dly_cnt;
		next_tx_strobe = 1'b0;
		if (tx_cnt == tx_div) begin
			next_tx_clk = 1'b1;
		end else if (tx_cnt == (tx_div >> 1)) begin
			next_tx_clk = 1'b0;
		end
		case (dly_state)
			DLY_IDLE: begin
				if (rgmii_ports_en && tx_cnt == tx_div) begin
					if (tx_dly == 8'h00) begin
						next_tx_strobe = 1'b1;
					end else begin
						next_dly_cnt = tx_dly;
						next_dly_state = DLY_WAIT;
					end
				end
			end
			DLY_WAIT: begin
				next_dly_cnt = dly_cnt - 8'h01;
				if (dly_cnt == 8'h01) begin
					next_tx_strobe = 1'b1;
					next_dly_state = DLY_IDLE;
				end
			end
			default: next_dly_state = DLY_IDLE;
		endcase
		// Ports off also drops a strobe still pending from the delay
		if (!rgmii_ports_en) begin
			next_tx_clk = 1'b0;
			next_tx_strobe = 1'b0;
			next_dly_state = DLY_IDLE;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tx_cnt <= 9'h000;
			rgmii_tx_clk <= 1'b0;
			rgmii_tx_strobe <= 1'b0;
			dly_cnt <= 8'h00;
			dly_state <= DLY_IDLE;
		end else begin
			tx_cnt <= next_tx_cnt;
			rgmii_tx_clk <= next_tx_clk;
			rgmii_tx_strobe <= next_tx_strobe;
			dly_cnt <= next_dly_cnt;
			dly_state <= next_dly_state;
		end
	end

	// Low-power divider: enable pulse once per LP_DIV cycles when dividing
	localparam int LPW = (LP_DIV > 1) ? $clog2(LP_DIV) : 1;
	logic [LPW-1:0] lp_cnt, next_lp_cnt;
	logic lp_active, next_lp_clk_en;

	assign lp_active = tile_control[`CTL_LPDIV_EN]
		&& (!tile_control[`CTL_DYN_MODE] || all_threads_paused);

	always_comb begin
		next_lp_cnt = lp_cnt;
		next_lp_clk_en = 1'b1;
		if (lp_active) begin
			next_lp_clk_en = (lp_cnt == '0);
			next_lp_cnt = (lp_cnt == LPW'(LP_DIV - 1)) ? '0 : lp_cnt + 1'b1;
		end else begin
			next_lp_cnt = '0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lp_cnt <= '0;
			lp_clk_en <= 1'b1;
		end else begin
			lp_cnt <= next_lp_cnt;
			lp_clk_en <= next_lp_clk_en;
		end
	end

	logic [3:0] osc_run;
	assign osc_run = {{2{ring_osc_control[`OSC_PERI_RUN]}},
		{2{ring_osc_control[`OSC_CORE_RUN]}}};

	ring_osc_counters #(
		.NUM(4),
		.WIDTH(OSC_WIDTH)
	) u_osc (
		.clk(clk),
		.run(osc_run),
		.osc_edge(osc_edge),
		.count(osc_count)
	);

	// Checks
	a_sec_lock_refuse: assert property (@(posedge clk) disable iff (rst)
		hit && ps_we && reg_num == `REG_SECURITY_CONFIG && security_config[`SEC_WRITE_LOCK]
		&& !otp_load |=> ps_refused && $stable(security_config))
		else $error("locked security register changed");
	a_lock_holds: assert property (@(posedge clk) disable iff (rst)
		security_config[`SEC_WRITE_LOCK] && !otp_load |=> security_config[`SEC_WRITE_LOCK])
		else $error("security lock dropped without reset");
	a_otp_copy: assert property (@(posedge clk) disable iff (rst)
		otp_load |=> security_config == ($past(otp_word) & `SEC_WMASK))
		else $error("security register not loaded from OTP");
	a_ctl_reserved: assert property (@(posedge clk) disable iff (rst)
		(tile_control & ~`CTL_WMASK) == `RST_WORD
		&& (ring_osc_control & ~`OSC_WMASK) == `RST_WORD)
		else $error("reserved control bit set");
	a_read_ack: assert property (@(posedge clk) disable iff (rst)
		hit && !ps_we && reg_num == `REG_TILE_CONTROL |=> ps_ack && ps_rdata == $past(tile_control))
		else $error("control read data wrong");
	a_tx_clk_rise: assert property (@(posedge clk) disable iff (rst)
		rgmii_ports_en && tx_cnt == tx_div && $stable(tile_control) |=> rgmii_tx_clk)
		else $error("transmit clock did not rise at divider value");
	a_tx_clk_fall: assert property (@(posedge clk) disable iff (rst)
		rgmii_ports_en && tx_div > 9'h001 && tx_cnt == (tx_div >> 1) |=> !rgmii_tx_clk)
		else $error("transmit clock did not fall at half value");
	a_dyn_hold: assert property (@(posedge clk) disable iff (rst)
		tile_control[`CTL_LPDIV_EN] && tile_control[`CTL_DYN_MODE] && !all_threads_paused
		|=> lp_clk_en)
		else $error("dynamic divider ran with threads active");
	a_static_div: assert property (@(posedge clk) disable iff (rst)
		tile_control[`CTL_LPDIV_EN] && !tile_control[`CTL_DYN_MODE] && lp_clk_en
		&& $stable(tile_control) ##1 $stable(tile_control) |-> !lp_clk_en)
		else $error("static divider did not divide");
	a_boot_status: assert property (@(posedge clk) disable iff (rst)
		!rst |=> tile_boot_status[`BOOT_PROC_HI:`BOOT_PROC_LO] == $past(processor_number)
		&& tile_boot_status[`BOOT_SECOND_CORE_OFF] == $past(second_core_off)
		&& tile_boot_status[`BOOT_FROM_RAM] == $past(boot_from_ram))
		else $error("boot status does not follow inputs");
	a_refused_with_ack: assert property (@(posedge clk) disable iff (rst)
		ps_refused |-> ps_ack)
		else $error("refusal without acknowledge");
	a_foreign_no_ack: assert property (@(posedge clk) disable iff (rst)
		ps_req && ps_res[7:0] != `PS_RES_TYPE |=> !ps_ack)
		else $error("foreign resource acknowledged");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (rst)
		hit && !ps_we && reg_num != `REG_TILE_CONTROL && reg_num != `REG_TILE_BOOT_STATUS
		&& reg_num != `REG_SECURITY_CONFIG && reg_num != `REG_RING_OSC_CONTROL
		|=> ps_rdata == `RST_WORD)
		else $error("unmapped register read not zero");
	a_ports_off_quiet: assert property (@(posedge clk) disable iff (rst)
		!rgmii_ports_en |=> !rgmii_tx_clk && !rgmii_tx_strobe)
		else $error("transmit clock or strobe active with ports off");
	a_boot_override: assert property (@(posedge clk) disable iff (rst)
		!rst |=> tile_boot_status[`BOOT_OVERRIDE] == $past(security_config[`SEC_OTP_BOOT]))
		else $error("boot override flag does not follow security");
	a_core_osc_hold: assert property (@(posedge clk) disable iff (rst)
		!ring_osc_control[`OSC_CORE_RUN] |=> $stable(osc_count[2*OSC_WIDTH-1:0]))
		else $error("core counters moved while stopped");
	a_peri_osc_hold: assert property (@(posedge clk) disable iff (rst)
		!ring_osc_control[`OSC_PERI_RUN] |=> $stable(osc_count[4*OSC_WIDTH-1:2*OSC_WIDTH]))
		else $error("peripheral counters moved while stopped");

	c_sec_refused: cover property (@(posedge clk) disable iff (rst) ps_refused);
	c_tx_strobe: cover property (@(posedge clk) disable iff (rst) rgmii_tx_strobe && tx_dly > 8'h01);
	c_otp_override: cover property (@(posedge clk) disable iff (rst) tile_boot_status[`BOOT_OVERRIDE]);
	c_dyn_divide: cover property (@(posedge clk) disable iff (rst)
		tile_control[`CTL_DYN_MODE] && all_threads_paused && !lp_clk_en);
	c_osc_write: cover property (@(posedge clk) disable iff (rst)
		hit && ps_we && reg_num == `REG_RING_OSC_CONTROL);
endmodule

// ==== tile_status_pkg.sv ====
package tile_status_pkg;
	typedef enum logic [1:0] {
		DLY_IDLE = 2'b01,
		DLY_WAIT = 2'b10
	} delay_state_t;
endpackage

// ==== tile_status_regs.svh ====
// Function
// - Control 25:18 sets transmit data delay
// - Divider counter drives transmit clock edges
// - Control bit 8 enables media ports
// - Dynamic mode divides only when threads paused
// - Static mode divides continuously when enabled
// - Control bit 4 enables low-power divider
// - Control bit 2 selects UTMI or ULPI
// - Control bit 1 enables ULPI support
// - Boot status shows processor number, PLL pins
// - Boot status flags RAM, JTAG, override
// - Boot status shows second core off, skip
// - Security bit 31 refuses further writes
// - Security register loaded from OTP word
// - Security bits 4, 14, 0 restrict debug
// - Security bits lock OTP sectors, redundancy
// - Security bit 5 boots from OTP
// - Oscillator control bits start four counters
// - Oscillators run asynchronous, give random bits
// - Counters sixteen bits, survive system reset
`ifndef TILE_STATUS_REGS_SVH
`define TILE_STATUS_REGS_SVH

`define PS_RES_TYPE 8'h0b
`define REG_TILE_CONTROL 8'h02
`define REG_TILE_BOOT_STATUS 8'h03
`define REG_SECURITY_CONFIG 8'h05
`define REG_RING_OSC_CONTROL 8'h06

`define RST_WORD 32'h0000_0000
`define CTL_WMASK 32'h03ff_ff36
`define SEC_WMASK 32'h8000_5fb1
`define OSC_WMASK 32'h0000_0003

`define CTL_TXDLY_HI 25
`define CTL_TXDLY_LO 18
`define CTL_TXDIV_HI 17
`define CTL_TXDIV_LO 9
`define CTL_RGMII_EN 8
`define CTL_DYN_MODE 5
`define CTL_LPDIV_EN 4
`define CTL_UTMI_SEL 2
`define CTL_ULPI_EN 1

`define BOOT_PROC_HI 23
`define BOOT_PROC_LO 16
`define BOOT_OVERRIDE 8
`define BOOT_SECOND_CORE_OFF 5
`define BOOT_SKIP_POLL 4
`define BOOT_FROM_RAM 3
`define BOOT_FROM_JTAG 2
`define BOOT_PLL_HI 1
`define BOOT_PLL_LO 0

`define SEC_WRITE_LOCK 31
`define SEC_GLOBAL_DEBUG_OFF 14
`define SEC_OTP_LOCK_ALL 12
`define SEC_SECTOR_HI 11
`define SEC_SECTOR_LO 8
`define SEC_OTP_REDUNDANCY 7
`define SEC_OTP_BOOT 5
`define SEC_JTAG_CFG_BLOCK 4
`define SEC_JTAG_TAP_OFF 0

`define OSC_CORE_RUN 1
`define OSC_PERI_RUN 0

`define LP_DIV_RATIO 4

`endif
